// ### hdl/lhcr_regs.v
// Host link control register and self-ID buffer base register bank.
//
// Behaviour
// RULE1 - Enhancement-use bit settable only while program-phy and attach bits both read 1.
// RULE2 - Software leaves enhancement settings alone while program-phy reads 0.
// RULE3 - Bits 21 and 20 of the host link control register read zero.
// RULE4 - Link-PHY communication allowed only while link power status is 1.
// RULE5 - PHY-domain access with PHY clock stopped aborts, or returns all ones if suppressed.
// RULE6 - Offsets DCh-F0h and 100h-11Ch lie in the PHY-clock domain.
// RULE7 - Software waits about 10 ms after setting link power status.
// RULE8 - Posted-write bit enables posted writes; changed only while attach bit is 0.
// RULE9 - Attach bit clears on hardware or software reset.
// RULE10 - Software sets attach bit when ready, then forces a bus reset.
// RULE11 - Attach bit 0 detaches the link: no receive, process or transmit.
// RULE12 - Writing software reset bit resets controller state, not PCI configuration.
// RULE13 - Software reset bit reads 1 during reset and clears itself after.
// RULE14 - Bits 15 to 0 of the host link control register read zero.
// RULE15 - Self-ID base holds a 2K-aligned address, bits 31-11 read/write.
// RULE16 - Self-ID base bits 10-0 ignore writes and read zero.
// RULE17 - Received self-ID quadlets are written to the buffer at the base address.
// RULE18 - Host link control sits at a set and a clear address; both read it.
// RULE19 - Ones written set or clear bits; zeros leave bits unchanged.
`timescale 1ns/1ps
`include "lhcr_defs.vh"
module lhcr_regs (
	input  wire        clk_sys,
	input  wire        reset,
	input  wire        req_valid,
	input  wire        req_write,
	input  wire [11:0] req_addr,
	input  wire [31:0] req_wdata,
	output wire        rsp_valid,
	output wire [31:0] rsp_rdata,
	output wire        rsp_target_abort,
	input  wire        suppress_target_abort,
	input  wire        phy_clock_running_pin,
	input  wire        generic_sw_may_program_phy_pin,
	input  wire        selfid_quadlet_valid,
	input  wire [8:0]  selfid_quadlet_index,
	input  wire [31:0] selfid_quadlet_data,
	output wire        selfid_wr_valid,
	output wire [31:0] selfid_wr_addr,
	output wire [31:0] selfid_wr_data,
	output wire        phy_enhancement_use,
	output wire        link_power_status,
	output wire        link_phy_comm_allow,
	output wire        posted_write_allow,
	output wire        bus_attach_enable,
	output wire        bus_attached,
	output wire        software_reset_trigger
);

	////////////////////////////////////////////////////////////////////////////////

	function in_phy_domain;
		input [11:0] a;
		begin
			in_phy_domain = ((a >= `LHCR_OFS_PHYDOM1_LO) && (a <= `LHCR_OFS_PHYDOM1_HI)) ||
			                ((a >= `LHCR_OFS_PHYDOM2_LO) && (a <= `LHCR_OFS_PHYDOM2_HI));
		end
	endfunction

	wire phy_clk_run;
	wire prog_phy;
	wire srst_busy;

	reg                    enh_q;
	reg                    lps_q;
	reg                    posted_q;
	reg                    attach_q;
	reg [`LHCR_SID_W-1:0]  sid_base_q;
	reg                    rsp_valid_q;
	reg [31:0]             rsp_rdata_q;
	reg                    rsp_abort_q;
	reg                    sid_valid_q;
	reg [31:0]             sid_addr_q;
	reg [31:0]             sid_data_q;
	reg [31:0]             hlc_rd;
	reg [31:0]             rd_d;
	reg                    abort_d;

	lhcr_sync2 u_sync_phyclk (
		.clk_sys (clk_sys),
		.reset   (reset),
		.din     (phy_clock_running_pin),
		.dout    (phy_clk_run)
	);

	lhcr_sync2 u_sync_prog (
		.clk_sys (clk_sys),
		.reset   (reset),
		.din     (generic_sw_may_program_phy_pin),
		.dout    (prog_phy)
	);

	wire wr_set = req_valid && req_write && (req_addr == `LHCR_OFS_HLC_SET);
	wire wr_clr = req_valid && req_write && (req_addr == `LHCR_OFS_HLC_CLR);
	wire wr_sid = req_valid && req_write && (req_addr == `LHCR_OFS_SID_BASE);

	// A software reset is started only from the set address.
	lhcr_srst u_srst (
		.clk_sys (clk_sys),
		.reset   (reset),
		.start   (wr_set && req_wdata[`LHCR_BIT_SRST]),
		.busy    (srst_busy)
	);

	////////////////////////////////////////////////////////////////////////////////

	// Software reset is a synchronous clear so that PCI configuration inputs stay untouched.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enh_q      <= `LHCR_RST_BIT;
			lps_q      <= `LHCR_RST_BIT;
			posted_q   <= `LHCR_RST_BIT;
			attach_q   <= `LHCR_RST_BIT; // RULE9
			sid_base_q <= `LHCR_RST_SID;
		end else if (srst_busy) begin
			enh_q      <= `LHCR_RST_BIT; // RULE12
			lps_q      <= `LHCR_RST_BIT; // RULE12
			posted_q   <= `LHCR_RST_BIT; // RULE12
			attach_q   <= `LHCR_RST_BIT; // RULE9
			sid_base_q <= `LHCR_RST_SID; // RULE12
		end else begin
			if (wr_set && req_wdata[`LHCR_BIT_ENH_USE] && prog_phy && attach_q) begin
				enh_q <= 1'b1; // RULE1
			end else if (wr_clr && req_wdata[`LHCR_BIT_ENH_USE]) begin
				enh_q <= 1'b0; // RULE19
			end
			if (wr_set && req_wdata[`LHCR_BIT_LPS]) begin
				lps_q <= 1'b1; // RULE19
			end else if (wr_clr && req_wdata[`LHCR_BIT_LPS]) begin
				lps_q <= 1'b0; // RULE19
			end
			// Changing posted writes under live traffic could reorder them, so it is locked.
			if (!attach_q && wr_set && req_wdata[`LHCR_BIT_POSTED]) begin
				posted_q <= 1'b1; // RULE8
			end else if (!attach_q && wr_clr && req_wdata[`LHCR_BIT_POSTED]) begin
				posted_q <= 1'b0; // RULE8
			end
			if (wr_set && req_wdata[`LHCR_BIT_ATTACH]) begin
				attach_q <= 1'b1; // RULE19
			end else if (wr_clr && req_wdata[`LHCR_BIT_ATTACH]) begin
				attach_q <= 1'b0; // RULE19
			end
			if (wr_sid) begin
				sid_base_q <= req_wdata[31:`LHCR_SID_LSB]; // RULE15
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always @* begin
		hlc_rd                       = 32'h00000000; // RULE3 RULE14
		hlc_rd[`LHCR_BIT_PROG_PHY]   = prog_phy;
		hlc_rd[`LHCR_BIT_ENH_USE]    = enh_q;
		hlc_rd[`LHCR_BIT_LPS]        = lps_q;
		hlc_rd[`LHCR_BIT_POSTED]     = posted_q;
		hlc_rd[`LHCR_BIT_ATTACH]     = attach_q;
		hlc_rd[`LHCR_BIT_SRST]       = srst_busy; // RULE13
		rd_d    = 32'h00000000;
		abort_d = 1'b0;
		if (in_phy_domain(req_addr) && !phy_clk_run) begin
			if (suppress_target_abort) begin
				rd_d = `LHCR_ALL_ONES; // RULE5 RULE6
			end else begin
				abort_d = 1'b1; // RULE5 RULE6
			end
		end else begin
			case (req_addr)
				`LHCR_OFS_HLC_SET: rd_d = hlc_rd; // RULE18
				`LHCR_OFS_HLC_CLR: rd_d = hlc_rd; // RULE18
				`LHCR_OFS_SID_BASE: rd_d = {sid_base_q, 11'h000}; // RULE16
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= 32'h00000000;
			rsp_abort_q <= 1'b0;
		end else begin
			rsp_valid_q <= req_valid;
			rsp_rdata_q <= (req_valid && !req_write) ? rd_d : 32'h00000000;
			rsp_abort_q <= req_valid && abort_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Self-ID quadlets are dropped while detached or resetting.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sid_valid_q <= 1'b0;
			sid_addr_q  <= 32'h00000000;
			sid_data_q  <= 32'h00000000;
		end else begin
			sid_valid_q <= selfid_quadlet_valid && attach_q && !srst_busy; // RULE11 RULE17
			sid_addr_q  <= {sid_base_q, selfid_quadlet_index, 2'b00}; // RULE17
			sid_data_q  <= selfid_quadlet_data;
		end
	end

	assign rsp_valid              = rsp_valid_q;
	assign rsp_rdata              = rsp_rdata_q;
	assign rsp_target_abort       = rsp_abort_q;
	assign selfid_wr_valid        = sid_valid_q;
	assign selfid_wr_addr         = sid_addr_q;
	assign selfid_wr_data         = sid_data_q;
	assign phy_enhancement_use    = enh_q;
	assign link_power_status      = lps_q;
	assign link_phy_comm_allow    = lps_q; // RULE4
	assign posted_write_allow     = posted_q;
	assign bus_attach_enable      = attach_q;
	assign bus_attached           = attach_q && !srst_busy; // RULE11
	assign software_reset_trigger = srst_busy;

endmodule // lhcr_regs

// ### hdl/lhcr_defs.vh
// Constants for the host link control register bank.
`ifndef LHCR_DEFS_VH
`define LHCR_DEFS_VH
`define LHCR_OFS_HLC_SET      12'h050
`define LHCR_OFS_HLC_CLR      12'h054
`define LHCR_OFS_SID_BASE     12'h064
`define LHCR_OFS_PHYDOM1_LO   12'h0dc
`define LHCR_OFS_PHYDOM1_HI   12'h0f0
`define LHCR_OFS_PHYDOM2_LO   12'h100
`define LHCR_OFS_PHYDOM2_HI   12'h11c
`define LHCR_BIT_PROG_PHY     23
`define LHCR_BIT_ENH_USE      22
`define LHCR_BIT_LPS          19
`define LHCR_BIT_POSTED       18
`define LHCR_BIT_ATTACH       17
`define LHCR_BIT_SRST         16
`define LHCR_SID_LSB          11
`define LHCR_SID_W            21
`define LHCR_RST_BIT          1'b0
`define LHCR_RST_SID          21'h000000
`define LHCR_ALL_ONES         32'hffffffff
`define LHCR_SRST_CYCLES      5'h10
`endif

// ### hdl/lhcr_sync2.v
// Two flip-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
module lhcr_sync2 (
	input  wire clk_sys,
	input  wire reset,
	input  wire din,
	output wire dout
);
	reg meta_q;
	reg sync_q;
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule // lhcr_sync2

// ### hdl/lhcr_srst.v
// Software reset sequencer: holds busy for a fixed number of cycles.
`timescale 1ns/1ps
`include "lhcr_defs.vh"
module lhcr_srst (
	input  wire clk_sys,
	input  wire reset,
	input  wire start,
	output wire busy
);
	reg [4:0] cnt_q;
	reg       busy_q;
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy_q <= 1'b0;
			cnt_q  <= 5'h00;
		end else if (start && !busy_q) begin
			busy_q <= 1'b1; // RULE13
			cnt_q  <= `LHCR_SRST_CYCLES - 5'h01;
		end else if (busy_q) begin
			if (cnt_q == 5'h00) begin
				busy_q <= 1'b0; // RULE13
			end else begin
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end
	assign busy = busy_q;
endmodule // lhcr_srst

// ### tb/lhcr_props.sv
// Port-level checks for the host link control register bank.
`timescale 1ns/1ps
module lhcr_props (
	input logic        clk_sys,
	input logic        reset,
	input logic        req_valid,
	input logic [11:0] req_addr,
	input logic        rsp_valid,
	input logic [31:0] rsp_rdata,
	input logic        rsp_target_abort,
	input logic        suppress_target_abort,
	input logic        selfid_quadlet_valid,
	input logic [8:0]  selfid_quadlet_index,
	input logic        selfid_wr_valid,
	input logic [31:0] selfid_wr_addr,
	input logic        phy_enhancement_use,
	input logic        link_power_status,
	input logic        link_phy_comm_allow,
	input logic        posted_write_allow,
	input logic        bus_attach_enable,
	input logic        bus_attached,
	input logic        software_reset_trigger
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_rsp_timing: assert property (req_valid |=> rsp_valid) else $error("answer missing");
	a_rsp_cause: assert property (rsp_valid |-> $past(req_valid)) else $error("stray answer");
	a_comm_gate: assert property (link_phy_comm_allow == link_power_status) else $error("comm gate");
	a_attach_gate: assert property (bus_attached |-> bus_attach_enable && !software_reset_trigger)
		else $error("attached while disabled");
	a_srst_length: assert property ($rose(software_reset_trigger) |-> ##15 software_reset_trigger
		##1 !software_reset_trigger) else $error("reset length");
	a_srst_clears: assert property ($rose(software_reset_trigger) |=> !bus_attach_enable && !link_power_status)
		else $error("reset left bits");
	a_host_rsvd: assert property (rsp_valid && $past(req_addr[11:3]) == 9'h00a |->
		(rsp_rdata & 32'h0030ffff) == 32'h0) else $error("reserved bits set");
	a_sid_rsvd: assert property (rsp_valid && $past(req_addr) == 12'h064 |-> rsp_rdata[10:0] == 11'h0)
		else $error("base low bits set");
	a_abort_form: assert property (rsp_target_abort |-> rsp_valid && rsp_rdata == 32'h0
		&& !$past(suppress_target_abort)) else $error("bad abort");
	a_enh_cond: assert property ($rose(phy_enhancement_use) |-> $past(bus_attach_enable))
		else $error("enhancement set while detached");
	a_posted_lock: assert property ($changed(posted_write_allow) |->
		!$past(bus_attach_enable) || software_reset_trigger) else $error("posted changed");
	a_sid_write: assert property (selfid_wr_valid |-> $past(selfid_quadlet_valid) && $past(bus_attached)
		&& selfid_wr_addr[10:0] == {$past(selfid_quadlet_index), 2'b00}) else $error("bad self-ID write");
	c_srst: cover property ($rose(software_reset_trigger));
	c_abort: cover property (rsp_target_abort);
	c_sid: cover property (selfid_wr_valid);
	c_enh: cover property ($rose(phy_enhancement_use));
endmodule // lhcr_props
bind lhcr_regs lhcr_props i_props (.*);

// ### tb/testbench.sv
// Self-checking bench for the host link control register bank.
`timescale 1ns/1ps
`include "lhcr_defs.vh"
module testbench;
	logic clk_sys, reset, req_valid, req_write, suppress_target_abort, selfid_quadlet_valid;
	logic phy_clock_running_pin, generic_sw_may_program_phy_pin;
	logic [11:0] req_addr;
	logic [31:0] req_wdata, selfid_quadlet_data, s, m, sid, rd, d;
	logic [8:0]  selfid_quadlet_index;
	logic        ab;
	int          fails, checks_done, i, k;
	logic [11:0] pa [5] = '{12'h0dc, 12'h0f0, 12'h100, 12'h11c, 12'h0d8};
	wire rsp_valid, rsp_target_abort, selfid_wr_valid, phy_enhancement_use, link_power_status;
	wire link_phy_comm_allow, posted_write_allow, bus_attach_enable, bus_attached, software_reset_trigger;
	wire [31:0] rsp_rdata, selfid_wr_addr, selfid_wr_data;
	lhcr_regs i_dut (.*);
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// Bit 22 may always be cleared; only its setting depends on bits 23 and 17.
	function automatic logic [31:0] nxt(input logic [31:0] o, input logic c, input logic [31:0] v);
		logic [31:0] mk;
		mk = 32'h000a0000 | ((c || (o[23] && o[17])) ? 32'h00400000 : 32'h0) | (o[17] ? 32'h0 : 32'h00040000);
		return c ? o & ~(v & mk) : o | (v & mk);
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task acc(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(negedge clk_sys);
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = v;
		@(negedge clk_sys);
		req_valid = 0;
		rd = rsp_rdata;
		ab = rsp_target_abort;
		chk(rsp_valid, 1);
	endtask
	task end_sim;
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{fails, checks_done, req_valid, req_write, req_addr, req_wdata} = 0;
		{suppress_target_abort, selfid_quadlet_valid, selfid_quadlet_index, selfid_quadlet_data} = 0;
		s = 65;
		reset = 1;
		// The PHY clock is kept running from the start, so no settling wait follows a power-status write.
		phy_clock_running_pin = 1;
		generic_sw_may_program_phy_pin = 1;
		repeat (10) @(negedge clk_sys);
		reset = 0;
		repeat (3) @(negedge clk_sys);
		m = 32'h00800000;
		sid = 0;
		for (i = 0; i < 80; i++) begin
			d = xs() & ~32'h00010000;
			if (!generic_sw_may_program_phy_pin) d[22] = 1'b0;
			k = xs() % 4;
			if (k < 2) begin
				acc(1, k ? 12'h054 : 12'h050, d);
				m = nxt(m, k[0], d);
			end else if (k == 2) begin
				acc(1, 12'h064, d);
				sid = d & 32'hfffff800;
			end else begin
				generic_sw_may_program_phy_pin = ~generic_sw_may_program_phy_pin;
				repeat (3) @(negedge clk_sys);
				m[23] = generic_sw_may_program_phy_pin;
			end
			acc(0, xs() % 2 ? 12'h050 : 12'h054, 0);
			chk(rd, m);
			chk({phy_enhancement_use, link_power_status, posted_write_allow, bus_attach_enable}, {m[22], m[19:17]});
			chk(link_phy_comm_allow, m[19]);
			chk(bus_attached, m[17]);
			acc(0, 12'h064, 0);
			chk(rd, sid);
		end
		acc(1, 12'h054, 32'h00020000);
		acc(1, 12'h050, 32'h000e0000);
		for (i = 0; i < 2; i++) begin
			d = xs();
			selfid_quadlet_index = d[8:0];
			selfid_quadlet_data = xs();
			@(negedge clk_sys);
			selfid_quadlet_valid = 1;
			@(negedge clk_sys);
			selfid_quadlet_valid = 0;
			chk(selfid_wr_valid, i == 0);
			if (i == 0) chk(selfid_wr_addr, {sid[31:11], selfid_quadlet_index, 2'b00});
			if (i == 0) chk(selfid_wr_data, selfid_quadlet_data);
			acc(1, 12'h054, 32'h00020000);
		end
		acc(1, 12'h050, 32'h000a0000);
		acc(1, 12'h050, 32'h00010000);
		k = 0;
		while (software_reset_trigger === 1'b1 && k < 40) begin
			@(negedge clk_sys);
			k++;
		end
		chk(k, `LHCR_SRST_CYCLES);
		acc(0, 12'h050, 0);
		chk(rd, {8'h00, generic_sw_may_program_phy_pin, 23'h0});
		acc(0, 12'h064, 0);
		chk(rd, 0);
		// A stopped PHY clock is seen only after the two-stage synchroniser.
		phy_clock_running_pin = 0;
		repeat (3) @(negedge clk_sys);
		for (i = 0; i < 10; i++) begin
			suppress_target_abort = (i >= 5);
			acc(0, pa[i % 5], 0);
			chk(ab, i % 5 < 4 && i < 5);
			chk(rd, (i % 5 < 4 && i >= 5) ? 32'hffffffff : 32'h0);
		end
		end_sim();
	end
endmodule // testbench
